// ===== hdl/mcrw_defines.vh
`ifndef MCRW_DEFINES_VH
`define MCRW_DEFINES_VH
// command codes of the register file
`define MCRW_CMD_DAC        8'hD0
`define MCRW_CMD_PG_DLY     8'hD1
`define MCRW_CMD_WD_FIRST   8'hD2
`define MCRW_CMD_WD_NEXT    8'hD3
`define MCRW_CMD_PAGE_MASK  8'hD4
`define MCRW_CMD_PADS       8'hD5
`define MCRW_CMD_BASE_ADDR  8'hD6
`define MCRW_CMD_ID         8'hD7
`define MCRW_CMD_LOT        8'hD8
`define MCRW_CMD_DISCH      8'hD9
`define MCRW_CMD_CFG        8'hDA
`define MCRW_CMD_STATUS     8'hDB
`define MCRW_PAGE_ALL       8'hFF
// field positions
`define MCRW_CFG_MODE_HI    5
`define MCRW_CFG_MODE_LO    4
`define MCRW_CFG_WD_GATE    0
`define MCRW_ST_DISCH       0
`define MCRW_ST_WD          1
// reset values
`define MCRW_RST_W16        16'h0000
`define MCRW_RST_W8         8'h00
`define MCRW_RST_BASE       7'h5C
`define MCRW_RST_MASK       8'hFF
// timing
`define MCRW_CLK_MHZ        200
`define MCRW_T_TICK_US      10
`define MCRW_TICK_CYC       (`MCRW_T_TICK_US * `MCRW_CLK_MHZ)
`define MCRW_T_BASE_US      200
`define MCRW_BASE_TICKS     (`MCRW_T_BASE_US / `MCRW_T_TICK_US)
`define MCRW_T_MS_US        1000
`define MCRW_MS_TICKS       (`MCRW_T_MS_US / `MCRW_T_TICK_US)
`define MCRW_SHARE_TO_TICKS (2 * `MCRW_BASE_TICKS)
`define MCRW_PG_MAX_MS      13100
`define MCRW_PG_MAX         (`MCRW_PG_MAX_MS * `MCRW_T_MS_US / `MCRW_T_BASE_US)
`define MCRW_WDN_MAX_MS     600
`define MCRW_WDN_MAX        (`MCRW_WDN_MAX_MS * `MCRW_MS_TICKS)
`define MCRW_WDF_MAX_MS     65000
`define MCRW_WDF_MAX        (`MCRW_WDF_MAX_MS)
`define MCRW_COEF_ONE       1024
`define MCRW_COEF_MAX       65536
`define MCRW_ADDR_OFS_MAX   4'd9
`endif

// ===== hdl/mcrw_mfr_cmd_regs.v
`include "mcrw_defines.vh"

module mcrw_mfr_cmd_regs #(
    parameter [11:0] TICK_CYC = `MCRW_TICK_CYC,
    parameter [2:0]  CHAN     = 3'd0,
    parameter [15:0] ID_CODE  = 16'h5A5A, // arbitrary value
    parameter [7:0]  LOT_CODE = 8'h3C     // arbitrary value
) (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    input  wire        cmd_wr_i,
    input  wire        cmd_rd_i,
    input  wire [7:0]  cmd_code_i,
    input  wire [15:0] cmd_wdata_i,
    input  wire [7:0]  page_i,
    output reg  [15:0] cmd_rdata_o,
    output reg         cmd_ack_o,
    output reg         cmd_nak_o,
    output reg         chan_sel_o,
    input  wire [6:0]  bus_addr_i,
    input  wire [3:0]  addr_offset_i,
    output reg  [6:0]  bus_addr_o,
    output reg         addr_match_o,
    input  wire        share_clk_i,
    input  wire        watchdog_kick_i,
    input  wire        channel_on_input0_i,
    input  wire        channel_on_input1_i,
    input  wire [3:0]  fault_line_i,
    input  wire [3:0]  fault_drive_i,
    input  wire [1:0]  addr_select_pad0_i,
    input  wire [1:0]  addr_select_pad1_i,
    input  wire        pg_valid_i,
    input  wire        chan_on_i,
    input  wire        rise_done_i,
    input  wire        chan_on_cmd_i,
    input  wire [15:0] vout_meas_i,
    input  wire [15:0] vout_cmd_i,
    input  wire        soft_done_i,
    input  wire [9:0]  soft_code_i,
    output reg         pwrgd_oe_o,
    output reg         alert_oe_o,
    output reg  [9:0]  dac_code_o,
    output reg         dac_connect_o,
    output reg         dac_soft_req_o,
    output reg         chan_enable_o
);

    localparam [3:0] WD_OFF   = 4'b0001;
    localparam [3:0] WD_ARM   = 4'b0010;
    localparam [3:0] WD_FIRST = 4'b0100;
    localparam [3:0] WD_NEXT  = 4'b1000;

    // exponent/mantissa word to ticks, scaled by mult, rounded, clamped
    function [31:0] l11_ticks;
        input [15:0] w;
        input [10:0] mult;
        input [31:0] maxv;
        reg signed [5:0] e;
        reg [47:0]       p;
        integer          sh;
        begin
            e = {w[15], w[15:11]};
            p = 48'h0;
            // negative mantissa counts as zero
            if (!w[10])
                p = {37'h0, w[10:0]} * {37'h0, mult};
            if (e >= 0) begin
                sh = e;
                p  = p << sh;
            end else begin
                sh = -e;
                p  = (p + (48'h1 << (sh - 1))) >> sh;
            end
            if (p > {16'h0, maxv})
                l11_ticks = maxv;
            else
                l11_ticks = p[31:0];
        end
    endfunction

    // two-flop synchronisers for every pin input
    reg [13:0] pin_m_q;
    reg [13:0] pin_s_q;
    reg        kick_d1_q;
    reg        share_d1_q;
    wire [13:0] pin_raw = {share_clk_i, watchdog_kick_i,
                           addr_select_pad1_i, addr_select_pad0_i,
                           channel_on_input1_i, channel_on_input0_i,
                           fault_line_i, 2'b00};
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_m_q    <= 14'h0000;
            pin_s_q    <= 14'h0000;
            kick_d1_q  <= 1'b0;
            share_d1_q <= 1'b0;
        end else begin
            pin_m_q    <= pin_raw;
            pin_s_q    <= pin_m_q;
            kick_d1_q  <= pin_s_q[12];
            share_d1_q <= pin_s_q[13];
        end
    end
    wire kick_rise  = pin_s_q[12] & ~kick_d1_q;
    wire share_edge = pin_s_q[13] & ~share_d1_q;

    // register file
    reg [9:0]  dac_q;
    reg [15:0] pg_dly_q;
    reg [15:0] wd_first_q;
    reg [15:0] wd_next_q;
    reg [7:0]  mask_q;
    reg [6:0]  base_q;
    reg [15:0] disch_q;
    reg [7:0]  cfg_q;
    reg [1:0]  flag_q;

    wire sel = (page_i == {5'h00, CHAN}) ||
               ((page_i == `MCRW_PAGE_ALL) && mask_q[CHAN]);
    wire wr_dac   = cmd_wr_i && (cmd_code_i == `MCRW_CMD_DAC) && sel;
    wire wr_cfg   = cmd_wr_i && (cmd_code_i == `MCRW_CMD_CFG) && sel;
    wire wr_disch = cmd_wr_i && (cmd_code_i == `MCRW_CMD_DISCH) && sel;
    wire wr_wdn   = cmd_wr_i && (cmd_code_i == `MCRW_CMD_WD_NEXT);
    wire wr_st    = cmd_wr_i && (cmd_code_i == `MCRW_CMD_STATUS);
    wire [1:0] mode = cfg_q[`MCRW_CFG_MODE_HI:`MCRW_CFG_MODE_LO];
    wire wd_gate = cfg_q[`MCRW_CFG_WD_GATE];

    // decoded tick counts, raw words kept for reads
    wire [31:0] pg_ticks = l11_ticks(pg_dly_q, 11'd5, `MCRW_PG_MAX);
    wire [31:0] wdn_ticks = l11_ticks(wd_next_q, 11'd100, `MCRW_WDN_MAX);
    wire [31:0] wdf_ticks = l11_ticks(wd_first_q, 11'd1, `MCRW_WDF_MAX);
    wire [31:0] coef_q10  = l11_ticks(disch_q, 11'd1024, `MCRW_COEF_MAX);

    wire dac_ok = wr_dac && chan_on_i && rise_done_i && mode[1];

    // simple registers, each write stores the raw word; discharge and config writes only when the page selects this channel
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pg_dly_q   <= `MCRW_RST_W16;
            wd_first_q <= `MCRW_RST_W16;
            wd_next_q  <= `MCRW_RST_W16;
            mask_q     <= `MCRW_RST_MASK;
            base_q     <= `MCRW_RST_BASE;
            disch_q    <= `MCRW_RST_W16;
            cfg_q      <= `MCRW_RST_W8;
        end else if (cmd_wr_i) begin
            case (cmd_code_i)
                `MCRW_CMD_PG_DLY:    pg_dly_q   <= cmd_wdata_i;
                `MCRW_CMD_WD_FIRST:  wd_first_q <= cmd_wdata_i;
                `MCRW_CMD_WD_NEXT:   wd_next_q  <= cmd_wdata_i;
                `MCRW_CMD_PAGE_MASK: mask_q     <= cmd_wdata_i[7:0];
                `MCRW_CMD_BASE_ADDR: base_q     <= cmd_wdata_i[6:0];
                `MCRW_CMD_DISCH: begin
                    if (sel)
                        disch_q <= cmd_wdata_i;
                end
                `MCRW_CMD_CFG: begin
                    if (sel)
                        cfg_q <= cmd_wdata_i[7:0];
                end
                default: ;
            endcase
        end
    end

    // converter code and connect control
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dac_q          <= 10'h000;
            dac_connect_o  <= 1'b0;
            dac_soft_req_o <= 1'b0;
        end else begin
            if (wr_cfg) begin
                if (cmd_wdata_i[5:4] == 2'b10) begin
                    dac_connect_o  <= 1'b1;
                    dac_soft_req_o <= 1'b0;
                end else if (cmd_wdata_i[5:4] == 2'b11) begin
                    dac_connect_o  <= 1'b0;
                    dac_soft_req_o <= 1'b1;
                end else begin
                    dac_connect_o  <= 1'b0;
                    dac_soft_req_o <= 1'b0;
                end
            end else if (dac_soft_req_o && soft_done_i) begin
                dac_connect_o  <= 1'b1;
                dac_soft_req_o <= 1'b0;
            end
            if (dac_soft_req_o && soft_done_i && !wr_cfg)
                dac_q <= soft_code_i;
            else if (dac_ok)
                dac_q <= cmd_wdata_i[9:0];
        end
    end

    // 10us tick, aligned to shared timebase edges while it runs
    reg [11:0] pre_q;
    reg [4:0]  base_cnt_q;
    reg [6:0]  ms_cnt_q;
    reg [5:0]  share_to_q;
    reg        tick_q;
    reg        base_tick_q;
    reg        ms_tick_q;
    wire share_on = (share_to_q < `MCRW_SHARE_TO_TICKS);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_q       <= 12'h000;
            base_cnt_q  <= 5'h00;
            ms_cnt_q    <= 7'h00;
            share_to_q  <= 6'h3F;
            tick_q      <= 1'b0;
            base_tick_q <= 1'b0;
            ms_tick_q   <= 1'b0;
        end else begin
            tick_q      <= 1'b0;
            base_tick_q <= 1'b0;
            ms_tick_q   <= 1'b0;
            if (share_edge && share_on) begin
                pre_q <= 12'h000;
            end else if (pre_q >= TICK_CYC - 12'd1) begin
                pre_q  <= 12'h000;
                tick_q <= 1'b1;
            end else begin
                pre_q <= pre_q + 12'd1;
            end
            if (share_edge)
                share_to_q <= 6'h00;
            else if (tick_q && share_to_q != 6'h3F)
                share_to_q <= share_to_q + 6'd1;
            if (tick_q) begin
                if (base_cnt_q >= `MCRW_BASE_TICKS - 1) begin
                    base_cnt_q  <= 5'h00;
                    base_tick_q <= 1'b1;
                end else begin
                    base_cnt_q <= base_cnt_q + 5'd1;
                end
                if (ms_cnt_q >= `MCRW_MS_TICKS - 1) begin
                    ms_cnt_q  <= 7'h00;
                    ms_tick_q <= 1'b1;
                end else begin
                    ms_cnt_q <= ms_cnt_q + 7'd1;
                end
            end
        end
    end

    // watchdog state machine
    reg [3:0]  wd_st_q;
    reg [15:0] wd_cnt_q;
    reg        wd_exp_q;
    reg        pg_q;
    wire wd_en = (wd_first_q != 16'h0000) && (wd_next_q != 16'h0000);
    wire kick = kick_rise || (wr_wdn && cmd_wdata_i != 16'h0000);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_st_q  <= WD_OFF;
            wd_cnt_q <= 16'h0000;
            wd_exp_q <= 1'b0;
        end else begin
            wd_exp_q <= 1'b0;
            case (wd_st_q)
                WD_OFF: begin
                    if (wd_en) begin
                        wd_st_q  <= wd_gate ? WD_ARM : WD_FIRST;
                        wd_cnt_q <= wdf_ticks[15:0];
                    end
                end
                WD_ARM: begin
                    if (!wd_en) begin
                        wd_st_q <= WD_OFF;
                    // skip the cycle in which our own expiry still shows power-good
                    end else if (pg_q && !wd_exp_q) begin
                        wd_st_q  <= WD_FIRST;
                        wd_cnt_q <= wdf_ticks[15:0];
                    end
                end
                WD_FIRST, WD_NEXT: begin
                    if (!wd_en) begin
                        wd_st_q <= WD_OFF;
                    end else if (kick) begin
                        wd_st_q  <= WD_NEXT;
                        wd_cnt_q <= wdn_ticks[15:0];
                    end else if ((wd_st_q == WD_FIRST) ? ms_tick_q : tick_q) begin
                        if (wd_cnt_q <= 16'd1) begin
                            wd_exp_q <= 1'b1;
                            wd_st_q  <= wd_gate ? WD_ARM : WD_NEXT;
                            wd_cnt_q <= wdn_ticks[15:0];
                        end else begin
                            wd_cnt_q <= wd_cnt_q - 16'd1;
                        end
                    end
                end
                default: wd_st_q <= WD_OFF;
            endcase
        end
    end

    // power-good assertion delay
    reg [15:0] pg_cnt_q;
    // timebase edges when present, internal 200us otherwise
    wire pg_tick = share_on ? share_edge : base_tick_q;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pg_q     <= 1'b0;
            pg_cnt_q <= 16'h0000;
        end else if (!pg_valid_i || (wd_exp_q && wd_gate)) begin
            pg_q     <= 1'b0;
            pg_cnt_q <= 16'h0000;
        end else if (!pg_q) begin
            if ({16'h0, pg_cnt_q} >= pg_ticks)
                pg_q <= 1'b1;
            else if (pg_tick)
                pg_cnt_q <= pg_cnt_q + 16'd1;
        end
    end

    // discharge check at turn-on
    reg        on_cmd_d1_q;
    reg        hold_q;
    wire [32:0] thr_prod = {17'h0, vout_cmd_i} * {16'h0, coef_q10[16:0]};
    wire [15:0] thr      = thr_prod[25:10];
    // coefficient above one skips the check
    wire chk_en  = (coef_q10 <= `MCRW_COEF_ONE);
    wire not_low = chk_en && (vout_meas_i >= thr);
    wire on_rise = chan_on_cmd_i && !on_cmd_d1_q;
    wire hold_d  = on_rise ? not_low : (hold_q && not_low);
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            on_cmd_d1_q   <= 1'b0;
            hold_q        <= 1'b0;
            chan_enable_o <= 1'b0;
        end else begin
            on_cmd_d1_q   <= chan_on_cmd_i;
            hold_q        <= hold_d;
            chan_enable_o <= chan_on_cmd_i && !hold_d;
        end
    end

    // sticky flags, write one to clear, a new event wins
    wire [1:0] flag_set = {wd_exp_q, on_rise && not_low};
    wire [1:0] flag_clr = wr_st ? cmd_wdata_i[1:0] : 2'b00;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q     <= 2'b00;
            alert_oe_o <= 1'b0;
            pwrgd_oe_o <= 1'b1;
        end else begin
            flag_q     <= (flag_q & ~flag_clr) | flag_set;
            // alert pulled low on expiry or discharge fault
            alert_oe_o <= |((flag_q & ~flag_clr) | flag_set);
            pwrgd_oe_o <= !pg_q;
        end
    end

    // device address from base plus offset
    wire [3:0] ofs = (addr_offset_i > `MCRW_ADDR_OFS_MAX) ?
                     `MCRW_ADDR_OFS_MAX : addr_offset_i;
    wire [6:0] dev_addr = base_q + {3'b000, ofs};
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_addr_o   <= `MCRW_RST_BASE;
            addr_match_o <= 1'b0;
        end else begin
            bus_addr_o   <= dev_addr;
            addr_match_o <= (bus_addr_i == dev_addr);
        end
    end

    // pad word: drive states, address codes, raw levels
    // 0 means this device pulls the pad low
    wire [15:0] pads = {pwrgd_oe_o ? 1'b0 : 1'b1, alert_oe_o ? 1'b0 : 1'b1,
                        ~fault_drive_i, pin_s_q[11:2]};

    // read mux and answer, registered one cycle after the request
    reg [15:0] rd_d;
    reg        known_d;
    always @* begin
        rd_d    = 16'h0000;
        known_d = 1'b1;
        case (cmd_code_i)
            `MCRW_CMD_DAC:       rd_d = sel ? {6'h00, dac_q} : 16'h0000;
            `MCRW_CMD_PG_DLY:    rd_d = pg_dly_q;
            `MCRW_CMD_WD_FIRST:  rd_d = wd_first_q;
            `MCRW_CMD_WD_NEXT:   rd_d = wd_next_q;
            `MCRW_CMD_PAGE_MASK: rd_d = {8'h00, mask_q};
            `MCRW_CMD_PADS:      rd_d = pads;
            `MCRW_CMD_BASE_ADDR: rd_d = {9'h000, base_q};
            `MCRW_CMD_ID:        rd_d = ID_CODE;
            `MCRW_CMD_LOT:       rd_d = sel ? {8'h00, LOT_CODE} : 16'h0000;
            `MCRW_CMD_DISCH:     rd_d = sel ? disch_q : 16'h0000;
            `MCRW_CMD_CFG:       rd_d = sel ? {8'h00, cfg_q} : 16'h0000;
            `MCRW_CMD_STATUS:    rd_d = {14'h0000, flag_q};
            default:             known_d = 1'b0;
        endcase
    end
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_rdata_o <= 16'h0000;
            cmd_ack_o   <= 1'b0;
            cmd_nak_o   <= 1'b0;
            chan_sel_o  <= 1'b0;
            dac_code_o  <= 10'h000;
        end else begin
            cmd_ack_o  <= (cmd_wr_i || cmd_rd_i) && known_d;
            cmd_nak_o  <= (cmd_wr_i || cmd_rd_i) && !known_d;
            chan_sel_o <= sel;
            dac_code_o <= dac_q;
            if (cmd_rd_i)
                cmd_rdata_o <= rd_d;
        end
    end

endmodule // mcrw_mfr_cmd_regs

// ===== sim/mcrw_chk.sv
module mcrw_chk #(
    parameter [2:0]  CHAN    = 3'd0,
    parameter [15:0] ID_CODE = 16'h0000
) (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        cmd_rd_i,
    input wire logic [7:0]  cmd_code_i,
    input wire logic [7:0]  page_i,
    input wire logic [15:0] cmd_rdata_o,
    input wire logic        chan_sel_o,
    input wire logic [6:0]  bus_addr_i,
    input wire logic [6:0]  bus_addr_o,
    input wire logic        addr_match_o,
    input wire logic        pg_valid_i,
    input wire logic        pwrgd_oe_o,
    input wire logic        alert_oe_o,
    input wire logic        chan_on_cmd_i,
    input wire logic        chan_enable_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // a read request of one command code
    sequence s_rd(c);
        cmd_rd_i && cmd_code_i == c;
    endsequence
    property p_id; s_rd(8'hD7) |=> cmd_rdata_o == ID_CODE; endproperty
    a_id: assert property (p_id) else $error("id word wrong");
    property p_dac_rsv; s_rd(8'hD0) |=> cmd_rdata_o[15:10] == 6'h00; endproperty
    a_dac_rsv: assert property (p_dac_rsv) else $error("code upper bits set");
    property p_base; s_rd(8'hD6) |=> cmd_rdata_o[15:7] == 9'h000; endproperty
    a_base: assert property (p_base) else $error("base upper bits set");
    // match flag and address come from the same sampled cycle
    property p_match; $past(resetn_i) |-> addr_match_o == (bus_addr_o == $past(bus_addr_i)); endproperty
    a_match: assert property (p_match) else $error("address match wrong");
    property p_pads; s_rd(8'hD5) |=> cmd_rdata_o[15:14] == {~$past(pwrgd_oe_o), ~$past(alert_oe_o)}; endproperty
    a_pads: assert property (p_pads) else $error("pull-low bits wrong");
    property p_pg_fall; $fell(pwrgd_oe_o) |-> $past(pg_valid_i, 2); endproperty
    a_pg_fall: assert property (p_pg_fall) else $error("power-good without cause");
    property p_pg_hold; !pg_valid_i [*4] |-> pwrgd_oe_o; endproperty
    a_pg_hold: assert property (p_pg_hold) else $error("power-good while invalid");
    property p_en; $rose(chan_enable_o) |-> $past(chan_on_cmd_i); endproperty
    a_en: assert property (p_en) else $error("enable without command");
    property p_sel; page_i != 8'hFF |=> chan_sel_o == ($past(page_i) == {5'h00, CHAN}); endproperty
    a_sel: assert property (p_sel) else $error("channel select wrong");
endmodule // mcrw_chk

bind mcrw_mfr_cmd_regs mcrw_chk #(.CHAN(CHAN), .ID_CODE(ID_CODE)) u_chk (
    .clk_sys_i, .resetn_i, .cmd_rd_i, .cmd_code_i, .page_i, .cmd_rdata_o, .chan_sel_o, .bus_addr_i,
    .bus_addr_o, .addr_match_o, .pg_valid_i, .pwrgd_oe_o, .alert_oe_o, .chan_on_cmd_i, .chan_enable_o
);

// ===== sim/mcrw_host_model.sv
module mcrw_host_model (
    input  wire logic clk_sys_i,
    input  wire logic share_run_i,
    input  wire logic kick_run_i,
    output logic      share_clk_o,
    output logic      watchdog_kick_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cnt_q = 6'h00;
    // timebase stands low between runs; odd offset keeps it off the clock phase
    initial begin
        share_clk_o = 1'b0;
        #1.3;
        forever #62.5 share_clk_o = share_run_i ? ~share_clk_o : 1'b0;
    end
    always @(posedge clk_sys_i) begin
        cnt_q <= cnt_q + 6'h01;
        watchdog_kick_o <= kick_run_i && cnt_q[5];
    end
endmodule // mcrw_host_model

// ===== sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [15:0] ID_WORD = 16'hC3A1; // arbitrary value
    logic        clk_sys_i = 1'b0, resetn_i = 1'b0, cmd_wr_i = 1'b0, cmd_rd_i = 1'b0, chan_on_i = 1'b1;
    logic [7:0]  cmd_code_i = 8'h00, page_i = 8'h00;
    logic [15:0] cmd_wdata_i = 16'h0000, vout_meas_i = 16'h0000, vout_cmd_i = 16'h03E8;
    logic [6:0]  bus_addr_i = 7'h00;
    logic [3:0]  addr_offset_i = 4'h0, fault_line_i = 4'hF, fault_drive_i = 4'h0;
    logic [1:0]  addr_select_pad0_i = 2'h0, addr_select_pad1_i = 2'h0;
    logic        channel_on_input0_i = 1'b0, channel_on_input1_i = 1'b0, pg_valid_i = 1'b0;
    logic        rise_done_i = 1'b1, chan_on_cmd_i = 1'b0, soft_done_i = 1'b0, share_run = 1'b0, kick_run = 1'b0;
    logic [9:0]  soft_code_i = 10'h155;
    wire logic   share_clk_i, watchdog_kick_i;
    logic [15:0] cmd_rdata_o;
    logic [9:0]  dac_code_o;
    logic [6:0]  bus_addr_o;
    logic        cmd_ack_o, cmd_nak_o, chan_sel_o, addr_match_o, pwrgd_oe_o, alert_oe_o;
    logic        dac_connect_o, dac_soft_req_o, chan_enable_o;
    logic [17:0] notes[$];
    logic [17:0] nt;
    int          err_count = 0, compares = 0, r;

    mcrw_mfr_cmd_regs #(.TICK_CYC(12'd4), .ID_CODE(ID_WORD)) dut (
        .clk_sys_i, .resetn_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_wdata_i, .page_i, .cmd_rdata_o,
        .cmd_ack_o, .cmd_nak_o, .chan_sel_o, .bus_addr_i, .addr_offset_i, .bus_addr_o, .addr_match_o,
        .share_clk_i, .watchdog_kick_i, .channel_on_input0_i, .channel_on_input1_i, .fault_line_i,
        .fault_drive_i, .addr_select_pad0_i, .addr_select_pad1_i, .pg_valid_i, .chan_on_i, .rise_done_i,
        .chan_on_cmd_i, .vout_meas_i, .vout_cmd_i, .soft_done_i, .soft_code_i, .pwrgd_oe_o, .alert_oe_o,
        .dac_code_o, .dac_connect_o, .dac_soft_req_o, .chan_enable_o);
    mcrw_host_model host (.clk_sys_i, .share_run_i(share_run), .kick_run_i(kick_run),
        .share_clk_o(share_clk_i), .watchdog_kick_o(watchdog_kick_i));

    always #2.5 clk_sys_i = ~clk_sys_i;

    task automatic complete_run;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access; the note tells the scoreboard what the answer must be
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [17:0] note);
        @(posedge clk_sys_i);
        #1;
        {cmd_wr_i, cmd_rd_i, cmd_code_i, cmd_wdata_i} = {w, ~w, c, d};
        notes.push_back(note);
        @(posedge clk_sys_i);
        #1;
        {cmd_wr_i, cmd_rd_i} = 2'b00;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d); acc(1'b1, c, d, 18'h00000); endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e); acc(1'b0, c, 16'h0000, {2'b01, e}); endtask
    // bounded wait; running out ends the run as a mismatch
    task automatic wait_lvl(ref logic s, input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk(what, {15'h0, v}, {15'h0, s});
        if (s !== v) complete_run();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    function automatic logic [1:0] pad_code(input int k);
        return {k != 0, k == 2};
    endfunction

    // scoreboard: oldest note against each answer
    initial forever begin
        @(posedge clk_sys_i);
        #1;
        if (cmd_ack_o === 1'b1 || cmd_nak_o === 1'b1) begin
            nt = notes.size() > 0 ? notes.pop_front() : 18'h3FFFF;
            chk("nak", {15'h0, nt[17]}, {15'h0, cmd_nak_o});
            if (nt[16]) chk("rdata", nt[15:0], cmd_rdata_o);
        end
    end

    initial begin
        void'($urandom(32'h05F30222));
        idle(2);
        resetn_i = 1'b1;
        rd(8'hD7, ID_WORD);
        wr(8'hD7, 16'h0000);
        rd(8'hD7, ID_WORD);
        rd(8'hD6, 16'h005C);
        rd(8'hD4, 16'h00FF);
        acc(1'b0, 8'hC0, 16'h0000, 18'h20000);
        // raw pad levels, random each pass
        repeat (4) begin
            {fault_line_i, fault_drive_i, channel_on_input0_i, channel_on_input1_i} = 10'($urandom);
            addr_select_pad0_i = pad_code($urandom_range(2));
            addr_select_pad1_i = pad_code($urandom_range(2));
            idle(4);
            rd(8'hD5, {2'b01, ~fault_drive_i, addr_select_pad1_i, addr_select_pad0_i, channel_on_input1_i,
                channel_on_input0_i, fault_line_i});
        end
        // offsets above nine act as nine
        repeat (3) begin
            r = $urandom;
            wr(8'hD6, r[15:0]);
            rd(8'hD6, {9'h000, r[6:0]});
            addr_offset_i = 4'($urandom_range(12));
            bus_addr_i = r[6:0] + (addr_offset_i > 4'd9 ? 7'd9 : {3'b000, addr_offset_i});
            idle(3);
            chk("addr", {9'h000, bus_addr_i}, {9'h000, bus_addr_o});
            chk("match", 16'h0001, {15'h0, addr_match_o});
        end
        for (int m = 0; m < 3; m++) begin
            wr(8'hDA, 16'(m << 4));
            wr(8'hD0, 16'hFC00 | 16'(m * 100 + 7));
            rd(8'hD0, m < 2 ? 16'h0000 : 16'h00CF);
        end
        chk("dac", 16'h00CF, {6'h00, dac_code_o});
        chk("connect", 16'h0001, {15'h0, dac_connect_o});
        rise_done_i = 1'b0;
        wr(8'hD0, 16'h0111);
        rd(8'hD0, 16'h00CF);
        rise_done_i = 1'b1;
        chan_on_i = 1'b0;
        wr(8'hD0, 16'h0122);
        rd(8'hD0, 16'h00CF);
        chan_on_i = 1'b1;
        wr(8'hDA, 16'h0030);
        wait_lvl(dac_soft_req_o, 1'b1, 10, "soft req");
        soft_done_i = 1'b1;
        idle(1);
        soft_done_i = 1'b0;
        rd(8'hD0, 16'h0155);
        wr(8'hD4, 16'h00FE);
        page_i = 8'hFF;
        rd(8'hD0, 16'h0000);
        chk("sel", 16'h0000, {15'h0, chan_sel_o});
        wr(8'hD4, 16'h00FF);
        rd(8'hD0, 16'h0155);
        page_i = 8'h00;
        wr(8'hD1, 16'h7BFF);
        rd(8'hD1, 16'h7BFF);
        wr(8'hD1, 16'h0001);
        pg_valid_i = 1'b1;
        idle(300);
        chk("pg early", 16'h0001, {15'h0, pwrgd_oe_o});
        wait_lvl(pwrgd_oe_o, 1'b0, 200, "pg internal");
        pg_valid_i = 1'b0;
        share_run = 1'b1;
        idle(100);
        pg_valid_i = 1'b1;
        idle(60);
        chk("pg shared early", 16'h0001, {15'h0, pwrgd_oe_o});
        wait_lvl(pwrgd_oe_o, 1'b0, 150, "pg shared");
        wr(8'hD2, 16'h0002);
        wr(8'hD3, 16'hF001);
        kick_run = 1'b1;
        idle(1000);
        chk("alert kicked", 16'h0000, {15'h0, alert_oe_o});
        kick_run = 1'b0;
        idle(30);
        chk("alert early", 16'h0000, {15'h0, alert_oe_o});
        wait_lvl(alert_oe_o, 1'b1, 200, "expiry");
        rd(8'hDB, 16'h0002);
        wr(8'hDA, 16'h0021);
        wait_lvl(pwrgd_oe_o, 1'b1, 150, "wd drop");
        wait_lvl(pwrgd_oe_o, 1'b0, 200, "pg again");
        wr(8'hD3, 16'h0000);
        wr(8'hDB, 16'h0002);
        idle(400);
        rd(8'hDB, 16'h0000);
        wr(8'hD9, 16'h0001);
        vout_meas_i = 16'd1100;
        chan_on_cmd_i = 1'b1;
        idle(8);
        chk("held", 16'h0000, {15'h0, chan_enable_o});
        rd(8'hDB, 16'h0001);
        vout_meas_i = 16'd500;
        wait_lvl(chan_enable_o, 1'b1, 10, "decayed");
        chan_on_cmd_i = 1'b0;
        vout_meas_i = 16'd1100;
        wr(8'hD9, 16'h0002);
        chan_on_cmd_i = 1'b1;
        wait_lvl(chan_enable_o, 1'b1, 4, "no check");
        chk("pending", 16'h0000, 16'(notes.size()));
        complete_run();
    end
endmodule // tb_top
